// *** shared/fp_pair_pkg.sv ***
/*
  Constants for the paired single-precision multiply / multiply-subtract
  datapath: register offsets, field positions, reset values, rounding codes.
  Assumes an APB3 host with 32-bit data and byte addresses on an 8-bit bus.
*/
package fp_pair_pkg;
  localparam logic [7:0]  OFF_CMD     = 8'h00;
  localparam logic [7:0]  OFF_SRC2_LO = 8'h04;
  localparam logic [7:0]  OFF_SRC2_HI = 8'h08;
  localparam logic [7:0]  OFF_SRC3_LO = 8'h0c;
  localparam logic [7:0]  OFF_SRC3_HI = 8'h10;
  localparam logic [7:0]  OFF_SRC4_LO = 8'h14;
  localparam logic [7:0]  OFF_SRC4_HI = 8'h18;
  localparam logic [7:0]  OFF_TAG     = 8'h1c;
  localparam logic [7:0]  OFF_SF      = 8'h20;
  localparam logic [7:0]  OFF_RES_LO  = 8'h24;
  localparam logic [7:0]  OFF_RES_HI  = 8'h28;
  localparam logic [7:0]  OFF_META    = 8'h2c;
  localparam logic [7:0]  OFF_LFLG    = 8'h30;
  localparam logic [7:0]  OFF_INT_ST  = 8'h34;
  localparam logic [7:0]  OFF_INT_EN  = 8'h38;
  localparam logic [7:0]  OFF_INT_CLR = 8'h3c;
  // command word fields
  localparam int CMD_OP = 0;
  localparam int CMD_SF = 1;
  localparam int CMD_QP = 3;
  localparam int CMD_F1 = 4;
  localparam int CMD_F2 = 11;
  localparam int CMD_F3 = 18;
  localparam int CMD_F4 = 25;
  // source tag register
  localparam int TAG_NAT2 = 0;
  localparam int TAG_NAT3 = 1;
  localparam int TAG_NAT4 = 2;
  localparam int TAG_DIS_LOW = 3;
  localparam int TAG_DIS_HIGH = 4;
  localparam logic [6:0] FIRST_LOW_REG  = 7'h02;
  localparam logic [6:0] FIRST_HIGH_REG = 7'h20;
  // status field byte: rc, then fault and trap disables, then assist mode
  localparam int SF_VD = 2;
  localparam int SF_DD = 3;
  localparam int SF_OD = 4;
  localparam int SF_UD = 5;
  localparam int SF_ID = 6;
  localparam int SF_SWA = 7;
  localparam logic [31:0] SF_RESET = 32'h7c7c7c7c;
  localparam logic [1:0] RC_NEAR = 2'h0;
  localparam logic [1:0] RC_DOWN = 2'h1;
  localparam logic [1:0] RC_UP   = 2'h2;
  localparam logic [1:0] RC_ZERO = 2'h3;
  // per-lane flag bits
  localparam int FLG_INV = 0;
  localparam int FLG_DEN = 1;
  localparam int FLG_SWF = 2;
  localparam int FLG_UNF = 3;
  localparam int FLG_OVF = 4;
  localparam int FLG_INX = 5;
  localparam int FLG_SWT = 6;
  localparam int FLG_W = 7;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DIS = 1;
  localparam int IRQ_FLT = 2;
  localparam int IRQ_TRP = 3;
  localparam int IRQ_W = 4;
  // result metadata
  localparam logic [16:0] RES_EXP = 17'h1003e;
  localparam logic        RES_SIGN = 1'b0;
  localparam int META_SIGN = 17;
  localparam int META_NAT = 18;
  // single-format constants and datapath geometry
  localparam logic [31:0] QNAN_DEF = 32'h7fc00000;
  localparam logic [30:0] SP_MAX = 31'h7f7fffff;
  localparam logic [30:0] SP_INF = 31'h7f800000;
  localparam int GUARD = 74;
  localparam logic [11:0] PROD_EXP_OFF = 12'h12c;
  localparam logic [11:0] ADD_EXP_OFF = 12'h096;
  localparam logic [11:0] NORM_OFF = 12'h035;
  typedef enum logic {ST_IDLE, ST_EXEC} st_type;
endpackage : fp_pair_pkg

// *** shared/fp_lane_if.sv ***
/*
  Lane carrier between the pair controller and one lane datapath.
  Assumes the controller drives operands and samples results combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
interface fp_lane_if;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] c;
  logic [1:0]  rc;
  logic        skip;
  logic        software_assist;
  logic [31:0] res;
  logic [6:0]  flg;
  logic        dflt;
  modport calc (input a, b, c, rc, skip, software_assist, output res, flg, dflt);
  modport ctl  (output a, b, c, rc, skip, software_assist, input res, flg, dflt);
endinterface : fp_lane_if
`default_nettype wire

// *** rtl/fp_lane_fms.sv ***
/*
  One lane: fused single-precision a*b - c with a single rounding.
  Assumes operands are stable; purely combinational, no clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fp_lane_fms
  import fp_pair_pkg::*;
(
  fp_lane_if.calc lane
);
  logic [7:0]  ea, eb, ec, e8;
  logic [22:0] fa, fb, fc;
  logic [23:0] ma, mb, mc;
  logic [47:0] mp;
  logic signed [11:0] ep, ecs, eref, en, d;
  logic [6:0]   dcl, top, kk;
  logic [127:0] big, sml, shr, sml_s, mag, norm, n, dn;
  logic [31:0]  rnd, fin;
  logic         inc, g, st, ovf, mx;

  assign {ea, fa} = lane.a[30:0];
  assign {eb, fb} = lane.b[30:0];
  assign {ec, fc} = lane.c[30:0];
  wire cv = ~lane.skip;
  wire sp = lane.a[31] ^ lane.b[31];
  wire sy = ~lane.c[31];
  wire za = ea == 8'h00;
  wire zb = eb == 8'h00;
  wire zc = ec == 8'h00;
  wire na = (ea == 8'hff) & (fa != 23'h0);
  wire nb = (eb == 8'hff) & (fb != 23'h0);
  wire nc = (ec == 8'hff) & (fc != 23'h0) & cv;
  wire ia = (ea == 8'hff) & (fa == 23'h0);
  wire ib = (eb == 8'hff) & (fb == 23'h0);
  wire ic = (ec == 8'hff) & (fc == 23'h0) & cv;
  wire sn = (na & ~fa[22]) | (nb & ~fb[22]) | (nc & ~fc[22]);
  wire den = (za & fa != 23'h0) | (zb & fb != 23'h0) | (cv & zc & fc != 23'h0);
  wire inv_mul = (ia & zb & fb == 23'h0) | (ib & za & fa == 23'h0);
  wire pinf = ia | ib;
  wire inv = sn | inv_mul | (pinf & ic & (sp != sy));

  assign ma = {~za, fa};
  assign mb = {~zb, fb};
  assign mc = cv ? {~zc, fc} : 24'h0;
  // exact product, no rounding here
  assign mp = ma * mb;
  assign ep = 12'({4'h0, za ? 8'h01 : ea}) + 12'({4'h0, zb ? 8'h01 : eb}) - PROD_EXP_OFF;
  assign ecs = 12'({4'h0, zc ? 8'h01 : ec}) - ADD_EXP_OFF;
  // a skipped third operand keeps its exponent, which must not pull the product off the window
  wire bigp = lane.skip | (ep >= ecs);
  assign d = bigp ? ep - ecs : ecs - ep;
  assign eref = bigp ? ep : ecs;
  assign big = bigp ? 128'(mp) << GUARD : 128'(mc) << GUARD;
  assign sml = bigp ? 128'(mc) << GUARD : 128'(mp) << GUARD;
  assign dcl = (d > 12'sd127) ? 7'h7f : d[6:0];
  assign shr = sml >> dcl;
  // bits shifted out below the window fold into bit 0; far below the round point
  assign sml_s = shr | {127'h0, (shr << dcl) != sml};
  wire sb = bigp ? sp : sy;
  wire ss = bigp ? sy : sp;
  wire sub = sb != ss;
  wire gt = big >= sml_s;
  // subtraction stays exact in the wide window
  assign mag = ~sub ? big + sml_s : (gt ? big - sml_s : sml_s - big);
  wire rs = (~sub | gt) ? sb : ss;
  wire zs = (lane.skip | (sp == sy & mp == 48'h0 & mc == 24'h0)) ? sp : (lane.rc == RC_DOWN);

  always_comb begin
    top = 7'h00;
    for (int i = 0; i < 128; i++) begin
      if (mag[i]) begin
        top = 7'(i);
      end
    end
  end

  assign en = 12'({5'h0, top}) + eref + NORM_OFF;
  assign norm = mag << (7'h7f - top);
  assign kk = (en < -12'sd125) ? 7'h7f : 7'(12'sd1 - en);
  assign dn = norm >> kk;
  assign n = (en > 12'sd0) ? norm : dn | {127'h0, (dn << kk) != norm};
  assign e8 = (en > 12'sd0) ? en[7:0] : 8'h00;
  assign g = n[103];
  assign st = n[102:0] != 103'h0;
  // single rounding step, mode from the selected status field
  always_comb begin
    case (lane.rc)
      RC_NEAR: inc = g & (st | n[104]);
      RC_DOWN: inc = rs & (g | st);
      RC_UP:   inc = ~rs & (g | st);
      default: inc = 1'b0;
    endcase
  end
  assign rnd = {1'b0, e8, n[126:104]} + {31'h0, inc};
  assign ovf = (en > 12'sd254) | (rnd[30:23] == 8'hff);
  assign mx = (lane.rc == RC_ZERO) | (lane.rc == RC_DOWN & ~rs) | (lane.rc == RC_UP & rs);
  assign fin = (mag == 128'h0) ? {zs, 31'h0} : ovf ? {rs, mx ? SP_MAX : SP_INF} : {rs, rnd[30:0]};
  wire inx = (mag != 128'h0) & (g | st | ovf);
  wire unf = (mag != 128'h0) & (en < 12'sd1) & (g | st);
  wire nan = na | nb | nc;

  // NaN and infinity defaults bypass the arithmetic
  assign lane.dflt = inv | nan | pinf | ic;
  assign lane.res = inv ? QNAN_DEF :
                    na ? (lane.a | 32'h00400000) :
                    nb ? (lane.b | 32'h00400000) :
                    nc ? (lane.c | 32'h00400000) :
                    pinf ? {sp, SP_INF} :
                    ic ? {sy, SP_INF} : fin;
  assign lane.flg[FLG_INV] = inv;
  assign lane.flg[FLG_DEN] = den;
  assign lane.flg[FLG_SWF] = den & lane.software_assist;
  assign lane.flg[FLG_UNF] = ~lane.dflt & unf;
  assign lane.flg[FLG_OVF] = ~lane.dflt & ovf;
  assign lane.flg[FLG_INX] = ~lane.dflt & inx;
  assign lane.flg[FLG_SWT] = ~lane.dflt & unf & lane.software_assist;
endmodule : fp_lane_fms
`default_nettype wire

// *** rtl/paired_fp_msub.sv ***
/*
  Paired single-precision multiply and multiply-subtract unit with an APB3
  register slave, per-lane exception flags and a level interrupt.
  Assumes APB3 on I_CLK, synchronous active-high reset, no wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module paired_fp_msub
  import fp_pair_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_IRQ
);
  st_type             st_r;
  logic [31:0]        cmd_r;
  logic [63:0]        src2_r;
  logic [63:0]        src3_r;
  logic [63:0]        src4_r;
  logic [4:0]         tag_r;
  logic [31:0]        sf_r;
  logic [31:0]        res_lo_r;
  logic [31:0]        res_hi_r;
  logic [31:0]        meta_r;
  logic [15:0]        lflg_r;
  logic [IRQ_W-1:0]   int_st_r;
  logic [IRQ_W-1:0]   int_en_r;
  logic [31:0]        prdata_r;
  logic [1:0]         fault_l;
  logic [1:0]         trap_l;
  logic [15:0]        lflg_nxt;
  logic [1:0]         dflt_l;

  fp_lane_if lane_bus[2] ();

  // address decode
  wire acc = I_PSEL & I_PENABLE;
  wire setup = I_PSEL & ~I_PENABLE;
  wire wr = acc & I_PWRITE;
  wire h_cmd = I_PADDR == OFF_CMD;
  wire h_s2l = I_PADDR == OFF_SRC2_LO;
  wire h_s2h = I_PADDR == OFF_SRC2_HI;
  wire h_s3l = I_PADDR == OFF_SRC3_LO;
  wire h_s3h = I_PADDR == OFF_SRC3_HI;
  wire h_s4l = I_PADDR == OFF_SRC4_LO;
  wire h_s4h = I_PADDR == OFF_SRC4_HI;
  wire h_tag = I_PADDR == OFF_TAG;
  wire h_sf = I_PADDR == OFF_SF;
  wire h_rl = I_PADDR == OFF_RES_LO;
  wire h_rh = I_PADDR == OFF_RES_HI;
  wire h_meta = I_PADDR == OFF_META;
  wire h_lflg = I_PADDR == OFF_LFLG;
  wire h_ist = I_PADDR == OFF_INT_ST;
  wire h_ien = I_PADDR == OFF_INT_EN;
  wire h_clr = I_PADDR == OFF_INT_CLR;
  wire mapped = h_cmd | h_s2l | h_s2h | h_s3l | h_s3h | h_s4l | h_s4h | h_tag | h_sf |
                h_rl | h_rh | h_meta | h_lflg | h_ist | h_ien | h_clr;
  // write-only and clear registers read as zero
  wire [31:0] rd_mux = ({32{h_s2l}} & src2_r[31:0]) | ({32{h_s2h}} & src2_r[63:32]) |
                       ({32{h_s3l}} & src3_r[31:0]) | ({32{h_s3h}} & src3_r[63:32]) |
                       ({32{h_s4l}} & src4_r[31:0]) | ({32{h_s4h}} & src4_r[63:32]) |
                       ({32{h_tag}} & {27'h0, tag_r}) | ({32{h_sf}} & sf_r) |
                       ({32{h_rl}} & res_lo_r) | ({32{h_rh}} & res_hi_r) |
                       ({32{h_meta}} & meta_r) | ({32{h_lflg}} & {16'h0, lflg_r}) |
                       ({32{h_ist}} & {28'h0, int_st_r}) | ({32{h_ien}} & {28'h0, int_en_r});

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc & ~mapped;
  assign O_PRDATA = prdata_r;
  assign O_IRQ = |(int_st_r & int_en_r);

  // issue decode; multiply takes the constant zero register as third source
  wire exec = st_r == ST_EXEC;
  wire msub = cmd_r[CMD_OP];
  wire qp = cmd_r[CMD_QP];
  wire [6:0] f1 = cmd_r[CMD_F1 +: 7];
  wire [6:0] f2 = msub ? cmd_r[CMD_F2 +: 7] : 7'h00;
  wire [6:0] f3 = cmd_r[CMD_F3 +: 7];
  wire [6:0] f4 = cmd_r[CMD_F4 +: 7];
  wire [7:0] sf_sel = sf_r[{cmd_r[CMD_SF +: 2], 3'h0} +: 8];

  function automatic logic reg_off(input logic [6:0] idx, input logic [4:0] tag);
    reg_off = (idx >= FIRST_HIGH_REG & tag[TAG_DIS_HIGH]) |
              (idx >= FIRST_LOW_REG & idx < FIRST_HIGH_REG & tag[TAG_DIS_LOW]);
  endfunction : reg_off

  // any involved register in a disabled partition blocks execution
  wire dis = reg_off(f1, tag_r) | reg_off(f2, tag_r) | reg_off(f3, tag_r) | reg_off(f4, tag_r);
  // the constant zero register never carries the token
  wire nat = tag_r[TAG_NAT3] | tag_r[TAG_NAT4] | (tag_r[TAG_NAT2] & f2 != 7'h00);

  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign lane_bus[g].a = src3_r[32*g +: 32];
    assign lane_bus[g].b = src4_r[32*g +: 32];
    assign lane_bus[g].c = src2_r[32*g +: 32];
    assign lane_bus[g].rc = sf_sel[1:0];
    assign lane_bus[g].skip = f2 == 7'h00;
    assign lane_bus[g].software_assist = sf_sel[SF_SWA];
    // each lane's flags kept at its own byte position
    assign lflg_nxt[8*g +: 8] = {1'b0, lane_bus[g].flg};
    assign dflt_l[g] = lane_bus[g].dflt;
    assign fault_l[g] = (lane_bus[g].flg[FLG_INV] & ~sf_sel[SF_VD]) |
                        (lane_bus[g].flg[FLG_DEN] & ~sf_sel[SF_DD]) |
                        lane_bus[g].flg[FLG_SWF];
    assign trap_l[g] = (lane_bus[g].flg[FLG_UNF] & ~sf_sel[SF_UD]) |
                       (lane_bus[g].flg[FLG_OVF] & ~sf_sel[SF_OD]) |
                       (lane_bus[g].flg[FLG_INX] & ~sf_sel[SF_ID]) |
                       lane_bus[g].flg[FLG_SWT];
    fp_lane_fms u_lane (
      .lane (lane_bus[g].calc)
    );
  end

  // the token skips the fault and trap checks; the disabled-partition check still applies
  wire go = exec & qp;
  wire raise = ~nat & (|fault_l);
  wire wr_en = go & ~dis & ~raise;
  wire flg_en = go & ~dis & ~nat;
  wire [IRQ_W-1:0] ev = {wr_en & ~nat & (|trap_l), go & ~dis & raise, go & dis, wr_en};
  wire [IRQ_W-1:0] clr = (wr & h_clr) ? I_PWDATA[IRQ_W-1:0] : {IRQ_W{1'b0}};
  // a new event wins over a clear in the same cycle
  wire [IRQ_W-1:0] int_st_nxt = (int_st_r & ~clr) | ev;
  wire [31:0] res_hi_nxt = nat ? 32'h0 : lane_bus[1].res;
  wire [31:0] res_lo_nxt = nat ? 32'h0 : lane_bus[0].res;
  wire [31:0] meta_nxt = {13'h0, nat, RES_SIGN, nat ? 17'h0 : RES_EXP};

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_r <= ST_IDLE;
      cmd_r <= 32'h0;
    end else begin
      st_r <= (wr & h_cmd) ? ST_EXEC : ST_IDLE;
      cmd_r <= (wr & h_cmd) ? I_PWDATA : cmd_r;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      src2_r <= 64'h0;
      src3_r <= 64'h0;
      src4_r <= 64'h0;
    end else begin
      if (wr & h_s2l) src2_r[31:0] <= I_PWDATA;
      if (wr & h_s2h) src2_r[63:32] <= I_PWDATA;
      if (wr & h_s3l) src3_r[31:0] <= I_PWDATA;
      if (wr & h_s3h) src3_r[63:32] <= I_PWDATA;
      if (wr & h_s4l) src4_r[31:0] <= I_PWDATA;
      if (wr & h_s4h) src4_r[63:32] <= I_PWDATA;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tag_r <= 5'h00;
      sf_r <= SF_RESET;
      int_en_r <= {IRQ_W{1'b0}};
      int_st_r <= {IRQ_W{1'b0}};
      prdata_r <= 32'h0;
    end else begin
      if (wr & h_tag) tag_r <= I_PWDATA[4:0];
      if (wr & h_sf) sf_r <= I_PWDATA;
      if (wr & h_ien) int_en_r <= I_PWDATA[IRQ_W-1:0];
      int_st_r <= int_st_nxt;
      // read data captured in the setup cycle so it is a flop in the access cycle
      if (setup) prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      res_lo_r <= 32'h0;
      res_hi_r <= 32'h0;
      meta_r <= 32'h0;
      lflg_r <= 16'h0;
    end else begin
      if (wr_en) begin
        res_lo_r <= res_lo_nxt;
        res_hi_r <= res_hi_nxt;
        meta_r <= meta_nxt;
      end
      if (flg_en) lflg_r <= lflg_nxt;
    end
  end

  a_res_exp_fixed: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en |=> meta_r[16:0] == ($past(nat) ? 17'h0 : RES_EXP) && meta_r[META_SIGN] == RES_SIGN)
    else $error("result exponent or sign wrong after write");

  a_token_result: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && nat |=> meta_r[META_NAT] && res_lo_r == 32'h0 && res_hi_r == 32'h0 && !$rose(int_st_r[IRQ_FLT]))
    else $error("token not written in place of result");

  a_pred_false_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
    exec && !qp |=> $stable(res_lo_r) && $stable(res_hi_r) && $stable(meta_r) && $stable(lflg_r)
      && ((int_st_r & ~$past(int_st_r)) == 4'h0))
    else $error("state changed with predicate false");

  a_disabled_block: assert property (@(posedge I_CLK) disable iff (I_RST)
    go && dis |=> $stable(res_lo_r) && $stable(res_hi_r) && int_st_r[IRQ_DIS] && !$rose(int_st_r[IRQ_DONE]))
    else $error("disabled register did not block execution");

  a_fault_no_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    go && !dis && raise |=> $stable(res_lo_r) && $stable(meta_r) && int_st_r[IRQ_FLT])
    else $error("enabled fault let destination be written");

  a_lane_concat: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && !nat |=> res_hi_r == $past(lane_bus[1].res) && res_lo_r == $past(lane_bus[0].res))
    else $error("lanes packed in wrong halves");

  a_default_lane: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && !nat && dflt_l[0] |=> res_lo_r[30:23] == 8'hff)
    else $error("default lane result not NaN or infinity");

  a_mpy_zero_src: assert property (@(posedge I_CLK) disable iff (I_RST)
    $rose(exec) && !$past(I_PWDATA[CMD_OP], 1) |-> lane_bus[0].skip && lane_bus[1].skip)
    else $error("multiply did not use the zero register");

  a_trap_report: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_en && !nat && lane_bus[1].flg[FLG_OVF] && !sf_sel[SF_OD] |=> int_st_r[IRQ_TRP] && int_st_r[IRQ_DONE])
    else $error("enabled overflow trap not reported");

  a_token_no_flags: assert property (@(posedge I_CLK) disable iff (I_RST)
    go && !dis && nat |=> int_st_r[IRQ_DONE] && $stable(lflg_r) && !$rose(int_st_r[IRQ_TRP]))
    else $error("token execution touched the lane flags");

  a_idle_no_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    !exec |=> $stable(res_lo_r) && $stable(res_hi_r) && $stable(meta_r) && $stable(lflg_r))
    else $error("result registers changed without an issued command");

  a_msub_zero_src: assert property (@(posedge I_CLK) disable iff (I_RST)
    exec && cmd_r[CMD_OP] |-> lane_bus[0].skip == (cmd_r[CMD_F2 +: 7] == 7'h00) && lane_bus[1].skip == lane_bus[0].skip)
    else $error("third operand use does not follow the zero register");
endmodule : paired_fp_msub
`default_nettype wire

// *** tb/fp_issue_model.sv ***
/*
  Issue-side model: the APB master that loads operands and issues commands.
  Assumes one clock shared with the unit; requests are made through xfer.
*/
`timescale 1ns/1ps
`default_nettype none
module fp_issue_model (
  input  wire logic        i_clk,
  input  wire logic        i_pready,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0;
  end

  // request held until pready is seen high at a rising edge, no fixed latency assumed
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= w;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
endmodule : fp_issue_model
`default_nettype wire

// *** tb/test_paired_fp_msub.sv ***
/*
  Self-checking bench for the paired multiply unit, driven over APB.
  Assumes fp_issue_model as the only bus master; reads are checked in order.
*/
`timescale 1ns/1ps
`default_nettype none
module test_paired_fp_msub
  import fp_pair_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [40:0] exp_q[$];
  logic [40:0] e;
  logic [1:0]  rcs[4];
  logic [1:0]  s;
  int          num_errors;
  int          comparisons;
  int          cyc = 0;
  logic [191:0] ops_a = {32'hc0000000, 32'h40000000, 32'h3fc00000,
                         32'h40400000, 32'h3f800000, 32'h3f800000};
  logic [191:0] ops_r = {32'hbf800001, 32'h3f800001, 32'h3f800001,
                         32'h3f800001, 32'h00000000, 32'h34800000};
  logic [191:0] ops_n = {32'h3f800000, 32'h00000000, 32'h3f800000,
                         32'h7f800000, 32'h00000000, 32'h00000000};

  paired_fp_msub dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_IRQ(irq));
  fp_issue_model m (.i_clk(clk), .i_pready(pready), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // whole run is about 430 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // each completed read takes the oldest note: {address, error, data}
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      check($sformatf("reg_%h", e[40:33]), {pslverr, prdata}, e[32:0]);
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] d, input logic er = 1'b0);
    exp_q.push_back({a, er, d});
    m.xfer(1'b0, a, 32'h0);
  endtask : rd

  task run(input logic [191:0] ops, input logic [31:0] c);
    for (int i = 0; i < 6; i++)
      wr(OFF_SRC2_LO + 8'(4 * i), ops[32*i +: 32]);
    wr(OFF_CMD, c);
  endtask : run

  task res(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] mt);
    rd(OFF_RES_LO, lo);
    rd(OFF_RES_HI, hi);
    rd(OFF_META, mt);
  endtask : res

  task endt(input string t);
    $display("end of %s", t);
  endtask : endt

  // dst 5, src3 7, src4 9: all in the low disable partition
  function automatic logic [31:0] cmd(input logic op, input logic [1:0] sf, input logic qp, input logic [6:0] f2);
    return {7'd9, 7'd7, f2, 7'd5, qp, sf, op};
  endfunction : cmd

  initial begin
    rst = 1'b1;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(32'h2a342047));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_SF, SF_RESET);
    rd(OFF_INT_ST, 32'h0);
    rd(OFF_META, 32'h0);
    rd(OFF_CMD, 32'h0);
    rd(8'h40, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    endt("reset");
    wr(OFF_INT_EN, 32'hf);
    // third-operand words nonzero: multiply must still ignore them
    run(ops_a, cmd(1'b0, 2'h0, 1'b1, 7'd11));
    res(32'h40c00000, 32'hc0400000, 32'h0001003e);
    check("irq", {32'h0, irq}, 33'h1);
    wr(OFF_INT_CLR, 32'hf);
    rd(OFF_INT_ST, 32'h0);
    check("irq", {32'h0, irq}, 33'h0);
    wr(OFF_CMD, cmd(1'b1, 2'h0, 1'b1, 7'd11));
    res(32'h40a00000, 32'hc0800000, 32'h0001003e);
    wr(OFF_CMD, cmd(1'b1, 2'h0, 1'b1, 7'd0));
    res(32'h40c00000, 32'hc0400000, 32'h0001003e);
    endt("arith");
    // a second rounding step would lose the 2^-46 term in the low lane
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++)
        rcs[j] = 2'($urandom);
      s = 2'($urandom);
      rcs[s] = 2'(k);
      wr(OFF_SF, {6'h1f, rcs[3], 6'h1f, rcs[2], 6'h1f, rcs[1], 6'h1f, rcs[0]});
      run(ops_r, cmd(1'b1, s, 1'b1, 7'd11));
      rd(OFF_RES_LO, rcs[s] == RC_UP ? 32'h3f800001 : 32'h3f800000);
      rd(OFF_RES_HI, rcs[s] == RC_DOWN ? 32'hbf800003 : 32'hbf800002);
      rd(OFF_LFLG, 32'h00002020);
    end
    endt("round");
    wr(OFF_INT_CLR, 32'hf);
    wr(OFF_SF, 32'h7c7c7c78);
    run(ops_n, cmd(1'b0, 2'h0, 1'b1, 7'd0));
    rd(OFF_INT_ST, 32'h4);
    rd(OFF_LFLG, 32'h00000001);
    res(32'h3f800000, 32'hbf800002, 32'h0001003e);
    check("irq", {32'h0, irq}, 33'h1);
    wr(OFF_SF, SF_RESET);
    wr(OFF_CMD, cmd(1'b0, 2'h0, 1'b1, 7'd0));
    res(32'h7fc00000, 32'h3f800000, 32'h0001003e);
    rd(OFF_LFLG, 32'h00000001);
    // high lane overflows with its trap enabled; third-operand exponent left large on purpose
    wr(OFF_INT_CLR, 32'hf);
    wr(OFF_SF, 32'h7c7c7c6c);
    run({32'h40000000, 32'h3f800000, 32'h7f000000, 32'h3f800000, 64'h7f0000007f000000}, cmd(1'b0, 2'h0, 1'b1, 7'd0));
    res(32'h3f800000, 32'h7f800000, 32'h0001003e);
    rd(OFF_INT_ST, 32'h9);
    rd(OFF_LFLG, 32'h00003000);
    wr(OFF_SF, SF_RESET);
    endt("faults");
    for (int i = 0; i < 3; i++) begin
      wr(OFF_TAG, 32'h0);
      wr(OFF_CMD, cmd(1'b1, 2'h0, 1'b1, 7'd11));
      wr(OFF_TAG, 32'h1 << i);
      wr(OFF_CMD, cmd(1'b1, 2'h0, 1'b1, 7'd11));
      res(32'h0, 32'h0, 32'h00040000);
    end
    wr(OFF_INT_CLR, 32'hf);
    wr(OFF_TAG, 32'h8);
    wr(OFF_CMD, cmd(1'b1, 2'h0, 1'b1, 7'd11));
    rd(OFF_INT_ST, 32'h2);
    res(32'h0, 32'h0, 32'h00040000);
    wr(OFF_TAG, 32'h0);
    wr(OFF_INT_CLR, 32'hf);
    wr(OFF_CMD, cmd(1'b1, 2'h0, 1'b0, 7'd11));
    rd(OFF_INT_ST, 32'h0);
    res(32'h0, 32'h0, 32'h00040000);
    endt("guards");
    wrap_up();
  end
endmodule : test_paired_fp_msub
`default_nettype wire
